/* File: otfl_defs.vh */
// Operation
// - Levels one to three show live in warning status bits 3, 2, 1; fault pin untouched.
// - Level four shows live in warning status bit 8; fault pin untouched.
// - Warning level drives fault pin and shows live bit 0; no shutdown.
// - Fault level latches shutdown, drives fault pin, sets fault status bit 8.
// - Register reads keep working during shutdown; contents kept while supply is good.
// - Shutdown releases on clear command after temperature fell below fault level, or when the supply is lost.
`ifndef OTFL_DEFS_VH
`define OTFL_DEFS_VH
`define OTFL_ADDR_WARN 4'h1
`define OTFL_ADDR_FAULT 4'h3
`define OTFL_REG_W 11
`define OTFL_BIT_WARN 0
`define OTFL_BIT_L3 1
`define OTFL_BIT_L2 2
`define OTFL_BIT_L1 3
`define OTFL_BIT_L4 8
`define OTFL_BIT_SHDN 8
`define OTFL_RST_REG 11'h000
`endif

/* File: otfl_sync.v */
`default_nettype none
module otfl_sync #(
  parameter W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  // Second stage alone reads the first, to keep metastability contained.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end
  assign q = s2_reg;
endmodule // otfl_sync
`default_nettype wire

/* File: otfl_top.v */
`include "otfl_defs.vh"
`default_nettype none
module otfl_top (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Comparator levels from the temperature sensor
  input wire thermal_level_one,
  input wire thermal_level_two,
  input wire thermal_level_three,
  input wire thermal_level_four,
  input wire thermal_warning,
  input wire thermal_fault,
  // Supply monitor and clear command
  input wire power_stage_supply_ok,
  input wire clear_faults_cmd,
  // Register read port
  input wire [3:0] rd_addr,
  input wire rd_en,
  output reg [10:0] rd_data,
  // Outputs
  output reg thermal_shutdown_latched,
  output reg fault_out_n
);
  reg rst1_reg;
  reg rst_n_reg;
  wire [7:0] sync_q;
  wire lv1;
  wire lv2;
  wire lv3;
  wire lv4;
  wire warn;
  wire flt;
  wire supply_ok;
  wire clr;
  reg [10:0] warn_stat;
  reg [10:0] fault_stat;
  reg shdn_next;
  wire [10:0] warn_bits;
  wire [10:0] fault_bits;
  wire hit_warn;
  wire hit_fault;
  reg [10:0] rd_next;
  reg pin_next;
  genvar g;

  // Reset release through two flip-flops.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst1_reg <= 1'b1;
      rst_n_reg <= rst1_reg;
    end
  end

  // The sensor and command come from outside this clock domain.
  otfl_sync #(
    .W(8)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n_reg),
    .d({clear_faults_cmd, power_stage_supply_ok, thermal_fault, thermal_warning,
        thermal_level_four, thermal_level_three, thermal_level_two, thermal_level_one}),
    .q(sync_q)
  );
  assign lv1 = sync_q[0];
  assign lv2 = sync_q[1];
  assign lv3 = sync_q[2];
  assign lv4 = sync_q[3];
  assign warn = sync_q[4];
  assign flt = sync_q[5];
  assign supply_ok = sync_q[6];
  assign clr = sync_q[7];

  // Each status bit is placed by its own position constant; nothing stops two equal constants from ORing their flags into one bit.
  generate
    for (g = 0; g < `OTFL_REG_W; g = g + 1)
    begin : g_stat
      wire take_l1;
      wire take_l2;
      wire take_l3;
      wire take_l4;
      wire take_warn;
      wire take_shdn;
      assign take_l1 = (g == `OTFL_BIT_L1);
      assign take_l2 = (g == `OTFL_BIT_L2);
      assign take_l3 = (g == `OTFL_BIT_L3);
      assign take_l4 = (g == `OTFL_BIT_L4);
      assign take_warn = (g == `OTFL_BIT_WARN);
      assign take_shdn = (g == `OTFL_BIT_SHDN);
      // Level flags are shown live and never reach the fault pin.
      assign warn_bits[g] = (take_l1 && lv1)
        || (take_l2 && lv2)
        || (take_l3 && lv3)
        || (take_l4 && lv4)
        || (take_warn && warn);
      assign fault_bits[g] = take_shdn && thermal_shutdown_latched;
    end
  endgenerate

  always @*
  begin
    warn_stat = warn_bits;
    fault_stat = fault_bits;
  end

  // Shutdown latch states.
  localparam ST_RUN = 1'b0;
  localparam ST_SHDN = 1'b1;

  // A clear while still hot is ignored, and the fault level wins over a clear in the same cycle.
  always @*
  begin
    shdn_next = thermal_shutdown_latched;
    case (thermal_shutdown_latched)
      ST_RUN:
      begin
        if (flt)
          shdn_next = ST_SHDN;
      end
      ST_SHDN:
      begin
        if (clr && !flt)
          shdn_next = ST_RUN;
      end
      default:
      begin
        shdn_next = ST_RUN;
      end
    endcase
    // Without a good supply, state is lost as on power-up.
    if (!supply_ok)
      shdn_next = ST_RUN;
  end

  always @*
  begin
    pin_next = 1'b1;
    if (warn)
      pin_next = 1'b0;
    if (thermal_shutdown_latched)
      pin_next = 1'b0;
  end

  assign hit_warn = (rd_addr == `OTFL_ADDR_WARN);
  assign hit_fault = (rd_addr == `OTFL_ADDR_FAULT);

  // Reads are served regardless of shutdown; an idle port keeps the last word.
  always @*
  begin
    rd_next = rd_data;
    if (rd_en)
    begin
      if (hit_warn)
        rd_next = warn_stat;
      else if (hit_fault)
        rd_next = fault_stat;
      else
        rd_next = `OTFL_RST_REG;
    end
  end

  always @(posedge clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      thermal_shutdown_latched <= ST_RUN;
    end
    else
    begin
      thermal_shutdown_latched <= shdn_next;
    end
  end

  always @(posedge clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      fault_out_n <= 1'b1;
    end
    else
    begin
      fault_out_n <= pin_next;
    end
  end

  always @(posedge clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rd_data <= `OTFL_RST_REG;
    end
    else
    begin
      rd_data <= rd_next;
    end
  end
endmodule // otfl_top
`default_nettype wire

/* File: otfl_mcu.sv */
`default_nettype none
module otfl_mcu (
  input wire logic go,
  input wire logic [3:0] a,
  input wire logic clr,
  output logic rd_en,
  output logic [3:0] rd_addr,
  output logic clear_faults_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  // An idle address shows its inverse so a stale value never reads as valid.
  assign rd_en = go;
  assign rd_addr = go ? a : ~a;
  assign clear_faults_cmd = clr;
endmodule // otfl_mcu
`default_nettype wire

/* File: otfl_chk.sv */
`default_nettype none
module otfl_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic thermal_warning,
  input wire logic thermal_fault,
  input wire logic clear_faults_cmd,
  input wire logic power_stage_supply_ok,
  input wire logic [3:0] rd_addr,
  input wire logic rd_en,
  input wire logic [10:0] rd_data,
  input wire logic thermal_shutdown_latched,
  input wire logic fault_out_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_shdn_set: assert property ((thermal_fault && power_stage_supply_ok)[*8] |-> thermal_shutdown_latched) else $error("set");
  a_pin_cause: assert property (!fault_out_n |-> $past(thermal_shutdown_latched) || $past(thermal_warning, 3)) else $error("pin");
  a_warn_pin: assert property (thermal_warning[*6] |-> !fault_out_n) else $error("warn");
  a_no_shdn: assert property (!thermal_fault[*5] |-> !$rose(thermal_shutdown_latched)) else $error("shdn");
  a_shdn_free: assert property ($fell(thermal_shutdown_latched) |-> !$past(power_stage_supply_ok, 3) ||
    ($past(clear_faults_cmd, 3) && !$past(thermal_fault, 3))) else $error("free");
  a_fault_read: assert property (rd_en && rd_addr == 4'h3 |=> rd_data[8] == $past(thermal_shutdown_latched)) else $error("rd");
  a_unmapped_zero: assert property (rd_en && rd_addr != 4'h1 && rd_addr != 4'h3 |=> rd_data == 11'h000) else $error("map");
endmodule // otfl_chk
bind otfl_top otfl_chk otfl_chk_i (.*);
`default_nettype wire

/* File: otfl_top_test.sv */
`default_nettype none
module otfl_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, arst_n = 0, go = 0, clr = 0, flt = 0, sd = 0, ok = 1, rd_en, clear_faults_cmd, shdn, fault_out_n;
  logic [4:0] lv = 0;
  logic [3:0] a = 0, rd_addr;
  logic [10:0] rd_data;
  int fails = 0, cmp_count = 0;
  otfl_mcu otfl_mcu_i (.go(go), .a(a), .clr(clr), .rd_en(rd_en), .rd_addr(rd_addr), .clear_faults_cmd(clear_faults_cmd));
  otfl_top otfl_top_i (.clk(clk), .arst_n(arst_n), .thermal_level_one(lv[4]), .thermal_level_two(lv[3]),
    .thermal_level_three(lv[2]), .thermal_level_four(lv[1]), .thermal_warning(lv[0]), .thermal_fault(flt),
    .power_stage_supply_ok(ok), .clear_faults_cmd(clear_faults_cmd), .rd_addr(rd_addr), .rd_en(rd_en),
    .rd_data(rd_data), .thermal_shutdown_latched(shdn), .fault_out_n(fault_out_n));
  initial forever #10 clk = ~clk;
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] ad);
    logic [11:0] e;
    e = {!(lv[0] | sd), ad == 4'h1 ? {2'h0, lv[1], 4'h0, lv[4:2], lv[0]} : ad == 4'h3 ? {2'h0, sd, 8'h00} : 11'h000};
    go = 1;
    a = ad;
    wt(1);
    go = 0;
    wt(1);
    cmp_count++;
    if ({fault_out_n, rd_data} !== e)
    begin
      fails++;
      $display("MISMATCH pin_and_rd_data exp %h got %h", e, {fault_out_n, rd_data});
    end
    cmp_count++;
    if (shdn !== sd)
    begin
      fails++;
      $display("MISMATCH thermal_shutdown_latched exp %b got %b", sd, shdn);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h1095));
    wt(6);
    arst_n = 1;
    wt(5);
    for (int i = 0; i < 40; i++)
    begin
      lv = 5'($urandom);
      flt = (i >= 16 && i < 28) || (i >= 36 && i < 39);
      ok = (i != 38);
      clr = (i >= 24 && i < 28) || (i >= 32 && i < 36);
      wt(6);
      sd = ok & (flt | (sd & !clr));
      rd(4'($urandom));
      rd(i[0] ? 4'h3 : 4'h1);
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule // otfl_top_test
`default_nettype wire
